/* File: hw/cwd_top.sv */
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "cwd_defines.svh"

module cwd_top
(
    // APB clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Blank-array clear of the configuration storage.
    input wire logic array_clear_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Programmer port.
    input wire logic prog_write,
    input wire logic prog_select_two,
    input wire logic [`CWD_WORD_W-1:0] prog_data,
    input wire logic prog_bulk_erase,
    // Memory erase requests.
    output logic program_memory_erase,
    output logic data_memory_erase,
    // Device state.
    input wire logic sleep_mode,
    // Decoded options.
    output cwd_pkg::cwd_osc_t oscillator_select,
    output logic ext_clock_high_power,
    output logic ext_clock_medium_power,
    output logic ext_clock_low_power,
    output logic internal_oscillator,
    output logic external_rc_oscillator,
    output logic crystal_mode,
    output logic watchdog_run,
    output logic clock_output_drive,
    output logic program_protect_on,
    output logic data_protect_on,
    output logic powerup_timer_on,
    output logic reset_pin_function,
    output logic reset_pin_pullup,
    output logic failsafe_monitor_enable,
    output logic clock_switchover_enable,
    output logic [1:0] brownout_enable_field,
    output logic software_brownout_enable,
    output logic options_loaded
);
    import cwd_pkg::*;

    // Turns a register index into its byte address.
    function automatic logic [31:0] idx_addr(input logic [15:0] idx);
        idx_addr = {14'h0000, idx, 2'b00};
    endfunction

    // Storage and state.
    logic [`CWD_WORD_W-1:0] nv_one_r;
    logic [`CWD_WORD_W-1:0] nv_two_r;
    logic [`CWD_WORD_W-1:0] nv_one_nxt;
    logic [`CWD_WORD_W-1:0] nv_two_nxt;
    logic [`CWD_WORD_W-1:0] act_one_r;
    logic [`CWD_WORD_W-1:0] act_two_r;
    logic [`CWD_CTRL_W-1:0] ctrl_r;
    cwd_state_t state_r;
    cwd_state_t state_nxt;
    logic perase_r;
    logic derase_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    // Decoder results before their output flops.
    cwd_osc_t d_osc;
    logic d_exth;
    logic d_extm;
    logic d_extl;
    logic d_int;
    logic d_rc;
    logic d_xtal;
    logic d_wdt;
    logic d_clko;
    logic d_pprot;
    logic d_dprot;
    logic d_putmr;
    logic d_rstf;
    logic d_rstpu;
    logic [13:0] dec_bus_r;

    // Bus decode.
    wire access = psel && penable;
    wire hit_one = (paddr == idx_addr(`CWD_IDX_WORD1));
    wire hit_two = (paddr == idx_addr(`CWD_IDX_WORD2));
    wire hit_ctrl = (paddr == idx_addr(`CWD_IDX_CTRL));
    wire hit_stat = (paddr == idx_addr(`CWD_IDX_STAT));
    wire hit_ro = hit_one || hit_two || hit_stat;
    wire hit_any = hit_ro || hit_ctrl;
    wire wr_ctrl = access && pwrite && hit_ctrl;
    wire bad_acc = !hit_any || (pwrite && hit_ro);

    // Programming events on the stored words.
    wire wr_one = prog_write && !prog_select_two && !prog_bulk_erase;
    wire wr_two = prog_write && prog_select_two && !prog_bulk_erase;
    wire pprot_was_on = !nv_one_r[`CWD_PROG_BIT];
    wire dprot_was_on = !nv_one_r[`CWD_DATA_BIT];
    wire pprot_lifted = wr_one && pprot_was_on && prog_data[`CWD_PROG_BIT];
    wire pprot_erased = prog_bulk_erase && pprot_was_on;
    wire dprot_erased = prog_bulk_erase && dprot_was_on;

    // Next value of the stored words; a bulk erase returns them to ones.
    assign nv_one_nxt = prog_bulk_erase ? `CWD_ERASED :
                        (wr_one ? prog_data : nv_one_r);
    assign nv_two_nxt = prog_bulk_erase ? `CWD_ERASED :
                        (wr_two ? prog_data : nv_two_r);

    // Read data selection; unused bits read as zero.
    wire [31:0] stat_word = {28'h0000000, d_dprot, d_pprot, d_wdt,
                             (state_r == CWD_ST_RUN)};
    wire [31:0] rd_word = hit_one ? {18'h00000, nv_one_r} :
                          hit_two ? {18'h00000, nv_two_r} :
                          hit_ctrl ? {29'h00000000, ctrl_r} :
                          hit_stat ? stat_word : 32'h00000000;

    // Loader sequencing: one load cycle after reset, then run.
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            CWD_ST_LOAD: state_nxt = CWD_ST_RUN;
            CWD_ST_RUN: state_nxt = CWD_ST_RUN;
        endcase
    end

    // Configuration storage, kept across device resets.
    // Of the two resets, only a blank-array clear touches these flops, so a device reset keeps them.
    always_ff @(posedge pclk or negedge array_clear_n)
    begin
        if (!array_clear_n)
        begin
            nv_one_r <= `CWD_ERASED;
            nv_two_r <= `CWD_ERASED;
        end
        else
        begin
            nv_one_r <= nv_one_nxt;
            nv_two_r <= nv_two_nxt;
        end
    end

    // Erase requests, each a one-cycle pulse.
    // A bulk erase and a protection lift both count as unprotecting the program.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            perase_r <= 1'b0;
            derase_r <= 1'b0;
        end
        else
        begin
            perase_r <= pprot_lifted || pprot_erased;
            derase_r <= dprot_erased;
        end
    end

    // Loader state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= CWD_ST_LOAD;
        else
            state_r <= state_nxt;
    end

    // Active copy is taken once in the load cycle and then held.
    // Later programming only changes the stored words, never the options in use.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act_one_r <= `CWD_ERASED;
            act_two_r <= `CWD_ERASED;
        end
        else if (state_r == CWD_ST_LOAD)
        begin
            act_one_r <= nv_one_r;
            act_two_r <= nv_two_r;
        end
    end

    // Software control register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= '0;
        else if (wr_ctrl)
            ctrl_r <= pwdata[`CWD_CTRL_W-1:0];
    end

    // Read data and error flag are captured during the setup cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_r <= pwrite ? 32'h00000000 : rd_word;
            pslverr_r <= bad_acc;
        end
    end

    // Option decoding from the held copy.
    // The decoder is purely combinational; its results are registered below.
    cwd_decode u_decode
    (
        .word_one(act_one_r),
        .word_two(act_two_r),
        .software_watchdog_enable(ctrl_r[`CWD_CTRL_SWDT]),
        .reset_pin_pullup_control(ctrl_r[`CWD_CTRL_WPU]),
        .sleep_mode(sleep_mode),
        .oscillator_select(d_osc),
        .ext_clock_high_power(d_exth),
        .ext_clock_medium_power(d_extm),
        .ext_clock_low_power(d_extl),
        .internal_oscillator(d_int),
        .external_rc_oscillator(d_rc),
        .crystal_mode(d_xtal),
        .watchdog_run(d_wdt),
        .clock_output_drive(d_clko),
        .program_protect_on(d_pprot),
        .data_protect_on(d_dprot),
        .powerup_timer_on(d_putmr),
        .reset_pin_function(d_rstf),
        .reset_pin_pullup(d_rstpu)
    );

    // Decoded options leave through flops; reset shows erased defaults.
    // The reset value is the decode of an erased word, so a blank part starts safely.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oscillator_select <= CWD_OSC_EXT_HIGH;
            dec_bus_r <= `CWD_DEC_RST;
        end
        else
        begin
            oscillator_select <= d_osc;
            dec_bus_r <= {d_exth, d_extm, d_extl, d_int, d_rc, d_xtal, d_wdt,
                          d_clko, d_pprot, d_dprot, d_putmr, d_rstf, d_rstpu,
                          (state_r == CWD_ST_RUN)};
        end
    end

    // Output fan-out of the option flops.
    assign ext_clock_high_power = dec_bus_r[13];
    assign ext_clock_medium_power = dec_bus_r[12];
    assign ext_clock_low_power = dec_bus_r[11];
    assign internal_oscillator = dec_bus_r[10];
    assign external_rc_oscillator = dec_bus_r[9];
    assign crystal_mode = dec_bus_r[8];
    assign watchdog_run = dec_bus_r[7];
    assign clock_output_drive = dec_bus_r[6];
    assign program_protect_on = dec_bus_r[5];
    assign data_protect_on = dec_bus_r[4];
    assign powerup_timer_on = dec_bus_r[3];
    assign reset_pin_function = dec_bus_r[2];
    assign reset_pin_pullup = dec_bus_r[1];
    assign options_loaded = dec_bus_r[0];

    // Raw fields passed on for blocks that decode them elsewhere.
    assign failsafe_monitor_enable = act_one_r[`CWD_FSM_BIT];
    assign clock_switchover_enable = act_one_r[`CWD_SWOV_BIT];
    assign brownout_enable_field = act_one_r[`CWD_BOR_MSB:`CWD_BOR_LSB];
    assign software_brownout_enable = ctrl_r[`CWD_CTRL_SBOR];

    // Bus answers and erase pulses; the slave never inserts wait states,
    // so every access finishes in its first access cycle.
    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = pslverr_r && access;
    assign program_memory_erase = perase_r;
    assign data_memory_erase = derase_r;

endmodule

/* File: hw/cwd_defines.svh */
`ifndef CWD_DEFINES_SVH
`define CWD_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define CWD_IDX_WORD1 16'h8007
`define CWD_IDX_WORD2 16'h8008
`define CWD_IDX_CTRL 16'h8010
`define CWD_IDX_STAT 16'h8011

// Width and erased value of a configuration word.
`define CWD_WORD_W 14
`define CWD_ERASED 14'h3fff

// Field positions in the first configuration word.
`define CWD_OSC_LSB 0
`define CWD_OSC_MSB 2
`define CWD_WDT_LSB 3
`define CWD_WDT_MSB 4
`define CWD_PUTMR_BIT 5
`define CWD_RSTPIN_BIT 6
`define CWD_PROG_BIT 7
`define CWD_DATA_BIT 8
`define CWD_BOR_LSB 9
`define CWD_BOR_MSB 10
`define CWD_CLKO_BIT 11
`define CWD_SWOV_BIT 12
`define CWD_FSM_BIT 13

// Field position in the second configuration word.
`define CWD_LOWV_BIT 13

// Field positions in the control and status registers.
`define CWD_CTRL_SWDT 0
`define CWD_CTRL_SBOR 1
`define CWD_CTRL_WPU 2
`define CWD_CTRL_W 3
`define CWD_STAT_LOADED 0
`define CWD_STAT_WDT 1
`define CWD_STAT_PPROT 2
`define CWD_STAT_DPROT 3

// Decoded option flops while in reset: the decode of an erased word.
`define CWD_DEC_RST 14'h2086

`endif

/* File: hw/cwd_pkg.sv */
package cwd_pkg;

    // Oscillator selection codes as held in the word.
    typedef enum logic [2:0] {
        CWD_OSC_XTAL_LOW = 3'h0,
        CWD_OSC_XTAL_STD = 3'h1,
        CWD_OSC_XTAL_FAST = 3'h2,
        CWD_OSC_RC = 3'h3,
        CWD_OSC_INT = 3'h4,
        CWD_OSC_EXT_LOW = 3'h5,
        CWD_OSC_EXT_MED = 3'h6,
        CWD_OSC_EXT_HIGH = 3'h7
    } cwd_osc_t;

    // Watchdog enable policy codes.
    typedef enum logic [1:0] {
        CWD_WDT_OFF = 2'h0,
        CWD_WDT_SOFT = 2'h1,
        CWD_WDT_AWAKE = 2'h2,
        CWD_WDT_ON = 2'h3
    } cwd_wdt_t;

    // Loader states.
    typedef enum logic [1:0] {
        CWD_ST_LOAD = 2'b01,
        CWD_ST_RUN = 2'b10
    } cwd_state_t;

endpackage

/* File: hw/cwd_decode.sv */
`timescale 1ns/1ps
`include "cwd_defines.svh"

module cwd_decode
(
    // Sampled configuration words.
    input wire logic [`CWD_WORD_W-1:0] word_one,
    input wire logic [`CWD_WORD_W-1:0] word_two,
    // Run-time controls.
    input wire logic software_watchdog_enable,
    input wire logic reset_pin_pullup_control,
    input wire logic sleep_mode,
    // Decoded options.
    output cwd_pkg::cwd_osc_t oscillator_select,
    output logic ext_clock_high_power,
    output logic ext_clock_medium_power,
    output logic ext_clock_low_power,
    output logic internal_oscillator,
    output logic external_rc_oscillator,
    output logic crystal_mode,
    output logic watchdog_run,
    output logic clock_output_drive,
    output logic program_protect_on,
    output logic data_protect_on,
    output logic powerup_timer_on,
    output logic reset_pin_function,
    output logic reset_pin_pullup
);
    import cwd_pkg::*;

    wire cwd_wdt_t policy;
    wire lowv_on;
    wire rst_sel;

    // Field extraction.
    assign oscillator_select = cwd_osc_t'(word_one[`CWD_OSC_MSB:`CWD_OSC_LSB]);
    assign policy = cwd_wdt_t'(word_one[`CWD_WDT_MSB:`CWD_WDT_LSB]);
    assign lowv_on = word_two[`CWD_LOWV_BIT];
    assign rst_sel = word_one[`CWD_RSTPIN_BIT];

    // External clock modes on the clock input pin.
    assign ext_clock_high_power = (oscillator_select == CWD_OSC_EXT_HIGH);
    assign ext_clock_medium_power = (oscillator_select == CWD_OSC_EXT_MED);
    assign ext_clock_low_power = (oscillator_select == CWD_OSC_EXT_LOW);
    // Internal oscillator frees the pin; RC runs on it.
    assign internal_oscillator = (oscillator_select == CWD_OSC_INT);
    assign external_rc_oscillator = (oscillator_select == CWD_OSC_RC);
    // Any of the three crystal codes takes both oscillator pins.
    assign crystal_mode = (oscillator_select == CWD_OSC_XTAL_FAST) ||
                          (oscillator_select == CWD_OSC_XTAL_STD) ||
                          (oscillator_select == CWD_OSC_XTAL_LOW);

    // Watchdog run decision from the policy, sleep and the software bit.
    assign watchdog_run = (policy == CWD_WDT_ON) ||
                          ((policy == CWD_WDT_AWAKE) && !sleep_mode) ||
                          ((policy == CWD_WDT_SOFT) && software_watchdog_enable);

    // Active-low enables in the word.
    assign clock_output_drive = !word_one[`CWD_CLKO_BIT];
    assign program_protect_on = !word_one[`CWD_PROG_BIT];
    assign data_protect_on = !word_one[`CWD_DATA_BIT];
    // The timer follows its own bit only, never the brown-out field.
    assign powerup_timer_on = !word_one[`CWD_PUTMR_BIT];

    // Low-voltage programming forces the reset function and ignores the bit.
    assign reset_pin_function = lowv_on || rst_sel;
    assign reset_pin_pullup = reset_pin_function || reset_pin_pullup_control;

endmodule

/* File: test/cwd_top_sva.sv */
`timescale 1ns/1ps
module cwd_top_sva
(
    // Clock, resets and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic array_clear_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic pslverr,
    // Programmer and erase requests.
    input wire logic prog_write,
    input wire logic prog_select_two,
    input wire logic [13:0] prog_data,
    input wire logic prog_bulk_erase,
    input wire logic program_memory_erase,
    input wire logic data_memory_erase,
    // Options.
    input wire logic sleep_mode,
    input wire cwd_pkg::cwd_osc_t oscillator_select,
    input wire logic watchdog_run,
    input wire logic clock_output_drive,
    input wire logic program_protect_on,
    input wire logic data_protect_on,
    input wire logic powerup_timer_on,
    input wire logic reset_pin_function,
    input wire logic options_loaded
);
    import cwd_pkg::*;
    logic [13:0] w1_r, w2_r, s1_r, s2_r;
    logic run_r;
    // Causes of the erase pulses and of a refused write.
    wire lift = prog_write && !prog_select_two && prog_data[7];
    wire pcause = !w1_r[7] && (prog_bulk_erase || lift);
    wire dcause = prog_bulk_erase && !w1_r[8];
    wire badw = psel && penable && pwrite && (paddr == 32'h0002001c || paddr == 32'h00020020);
    // Shadow of the stored words as the programmer leaves them.
    always_ff @(posedge pclk or negedge array_clear_n)
    begin
        if (!array_clear_n)
        begin
            w1_r <= 14'h3fff;
            w2_r <= 14'h3fff;
        end
        else if (prog_bulk_erase)
        begin
            w1_r <= 14'h3fff;
            w2_r <= 14'h3fff;
        end
        else if (lift || (prog_write && !prog_select_two))
            w1_r <= prog_data;
        else if (prog_write)
            w2_r <= prog_data;
    end
    // The copy in use is taken at the first edge after reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_r <= 1'b0;
        else
            run_r <= 1'b1;
    end
    always_ff @(posedge pclk)
    begin
        if (!run_r)
        begin
            s1_r <= w1_r;
            s2_r <= w2_r;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Decoded options follow the copy taken at reset, not later programming.
    AST_OSC: assert property (options_loaded |-> oscillator_select == s1_r[2:0])
        else $error("Oscillator code differs from the sampled word.");
    AST_CLKO: assert property (options_loaded |-> clock_output_drive == !s1_r[11])
        else $error("Clock output drive wrong.");
    AST_PROT: assert property (options_loaded |->
        program_protect_on == !s1_r[7] && data_protect_on == !s1_r[8])
        else $error("Protection decode wrong.");
    AST_PUTMR: assert property (options_loaded |-> powerup_timer_on == !s1_r[5])
        else $error("Power-up timer decode wrong.");
    AST_RSTPIN: assert property (options_loaded |->
        reset_pin_function == (s2_r[13] || s1_r[6]))
        else $error("Reset pin function wrong.");
    AST_WDT: assert property (options_loaded && $past(options_loaded) && s1_r[4:3] != 2'h1
        |-> watchdog_run == (s1_r[4] && (s1_r[3] || !$past(sleep_mode))))
        else $error("Watchdog run state wrong.");
    AST_PERASE: assert property (pcause |=> program_memory_erase)
        else $error("Program memory erase missing.");
    AST_DERASE: assert property (data_memory_erase == $past(dcause))
        else $error("Data memory erase wrong.");
    AST_ERR: assert property (badw |-> pslverr)
        else $error("Write to a configuration word not refused.");
    // Main scenarios.
    cover property (program_memory_erase && data_memory_erase);
    cover property (options_loaded && sleep_mode && watchdog_run);
    cover property (badw);
endmodule

/* File: test/cwd_prog_model.sv */
`timescale 1ns/1ps
module cwd_prog_model
(
    // Clock.
    input wire logic pclk,
    // Programmer port.
    output logic prog_write,
    output logic prog_select_two,
    output logic [13:0] prog_data,
    output logic prog_bulk_erase
);
    // Idle values at time zero.
    initial
    begin
        prog_write = 1'b0;
        prog_select_two = 1'b0;
        prog_data = 14'h0;
        prog_bulk_erase = 1'b0;
    end
    // One whole word per pulse; select and data are scrambled once it is over.
    task automatic put_word(input logic sel, input logic [13:0] data);
        @(posedge pclk);
        prog_write <= 1'b1;
        prog_select_two <= sel;
        prog_data <= data;
        @(posedge pclk);
        prog_write <= 1'b0;
        prog_select_two <= ~sel;
        prog_data <= ~data;
    endtask
    // Bulk erase returns both words to the blank state.
    task automatic wipe();
        @(posedge pclk);
        prog_bulk_erase <= 1'b1;
        @(posedge pclk);
        prog_bulk_erase <= 1'b0;
    endtask
endmodule

/* File: test/tb_cwd_top.sv */
`timescale 1ns/1ps
module tb_cwd_top;
    import cwd_pkg::*;
    localparam logic [31:0] a_w1 = 32'h0002001c;
    localparam logic [31:0] a_w2 = 32'h00020020;
    localparam logic [31:0] a_ct = 32'h00020040;
    localparam logic [31:0] a_st = 32'h00020044;
    localparam logic [31:0] a_bad = 32'h00020048;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic array_clear_n = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic sleep_mode = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [13:0] prog_data, w1, w2;
    logic [1:0] brownout_enable_field;
    cwd_osc_t oscillator_select;
    logic pready, pslverr, program_memory_erase, data_memory_erase, prog_write, prog_select_two;
    logic prog_bulk_erase, options_loaded, software_brownout_enable, ext_clock_high_power;
    logic ext_clock_medium_power, ext_clock_low_power, internal_oscillator, crystal_mode;
    logic external_rc_oscillator, watchdog_run, clock_output_drive, program_protect_on;
    logic data_protect_on, powerup_timer_on, reset_pin_function, reset_pin_pullup;
    logic failsafe_monitor_enable, clock_switchover_enable;
    int failures = 0;
    int cmp_count = 0;
    cwd_top dut (.pclk, .presetn, .array_clear_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .prog_write, .prog_select_two, .prog_data, .prog_bulk_erase,
        .program_memory_erase, .data_memory_erase, .sleep_mode, .oscillator_select,
        .ext_clock_high_power, .ext_clock_medium_power, .ext_clock_low_power,
        .internal_oscillator, .external_rc_oscillator, .crystal_mode, .watchdog_run,
        .clock_output_drive, .program_protect_on, .data_protect_on, .powerup_timer_on,
        .reset_pin_function, .reset_pin_pullup, .failsafe_monitor_enable,
        .clock_switchover_enable, .brownout_enable_field, .software_brownout_enable,
        .options_loaded);
    cwd_prog_model prog (.pclk, .prog_write, .prog_select_two, .prog_data, .prog_bulk_erase);
    always #2.5 pclk = ~pclk;
    // Comparison and verdict.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Counts: %0d comparisons, %0d mismatches.", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
        input logic [31:0] exp, input logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        if (!wr)
            chk(prdata, exp);
        chk(32'(pslverr), 32'(err));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reset pulse, then wait until the decoded options are in use.
    task automatic restart();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        chk(32'({oscillator_select, ext_clock_high_power, watchdog_run, clock_output_drive,
            program_protect_on, data_protect_on, powerup_timer_on, reset_pin_function,
            reset_pin_pullup, options_loaded, program_memory_erase, data_memory_erase}),
            32'h00003e18);
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
    endtask
    // Every static option output against the two words.
    task automatic opts(input logic [13:0] a, input logic [13:0] b);
        chk({13'h0, oscillator_select, ext_clock_high_power, ext_clock_medium_power,
            ext_clock_low_power, internal_oscillator, external_rc_oscillator, crystal_mode,
            clock_output_drive, program_protect_on, data_protect_on, powerup_timer_on,
            reset_pin_function, failsafe_monitor_enable, clock_switchover_enable,
            brownout_enable_field, options_loaded},
            {13'h0, a[2:0], a[2:0] == 3'h7, a[2:0] == 3'h6, a[2:0] == 3'h5, a[2:0] == 3'h4,
            a[2:0] == 3'h3, a[2:0] < 3'h3, !a[11], !a[7], !a[8], !a[5], b[13] | a[6], a[13],
            a[12], a[10:9], 1'b1});
    endtask
    // Main sequence.
    initial
    begin
        logic [2:0] c;
        @(posedge pclk);
        array_clear_n <= 1'b0;
        @(posedge pclk);
        array_clear_n <= 1'b1;
        repeat (18) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        opts(14'h3fff, 14'h3fff);
        apb(1'b0, a_w1, 32'h0, 32'h3fff, 1'b0);
        apb(1'b0, a_w2, 32'h0, 32'h3fff, 1'b0);
        apb(1'b0, a_st, 32'h0, 32'h3, 1'b0);
        apb(1'b1, a_w1, 32'h0, 32'h0, 1'b1);
        apb(1'b0, a_w1, 32'h0, 32'h3fff, 1'b0);
        apb(1'b0, a_bad, 32'h0, 32'h0, 1'b1);
        $display("Erased defaults test done.");
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            w1 = {c[1], c[0], c[2], c[1:0], 2'b11, c[1], c[0], c[1:0], c};
            w2 = {c[2], 13'h1fff};
            prog.put_word(1'b0, w1);
            prog.put_word(1'b1, w2);
            restart();
            opts(w1, w2);
            chk(32'(watchdog_run), 32'(c[1]));
            @(posedge pclk);
            sleep_mode <= 1'b1;
            repeat (2) @(posedge pclk);
            #1;
            chk(32'(watchdog_run), 32'(c[1] & c[0]));
            apb(1'b1, a_ct, 32'h7, 32'h0, 1'b0);
            apb(1'b0, a_ct, 32'h0, 32'h7, 1'b0);
            #1;
            chk(32'({watchdog_run, reset_pin_pullup, software_brownout_enable}),
                32'({c[0], 2'b11}));
            apb(1'b1, a_ct, 32'h0, 32'h0, 1'b0);
            prog.put_word(1'b0, w1 ^ 14'h0007);
            sleep_mode <= 1'b0;
            repeat (2) @(posedge pclk);
            #1;
            chk(32'({reset_pin_pullup, oscillator_select}), 32'({c[2] | c[1], c}));
            apb(1'b0, a_w1, 32'h0, 32'(w1 ^ 14'h0007), 1'b0);
        end
        $display("Option decode test done.");
        prog.put_word(1'b0, 14'h3e7f);
        restart();
        opts(14'h3e7f, 14'h3fff);
        apb(1'b0, a_st, 32'h0, 32'hf, 1'b0);
        prog.put_word(1'b0, 14'h3eff);
        #1;
        chk(32'({program_memory_erase, data_memory_erase}), 32'h2);
        @(posedge pclk);
        #1;
        chk(32'({program_memory_erase, data_memory_erase}), 32'h0);
        prog.put_word(1'b0, 14'h3e7f);
        prog.wipe();
        #1;
        chk(32'({program_memory_erase, data_memory_erase}), 32'h3);
        restart();
        opts(14'h3fff, 14'h3fff);
        apb(1'b0, a_w2, 32'h0, 32'h3fff, 1'b0);
        $display("Erase effects test done.");
        complete_run();
    end
    // Cuts a hang short.
    initial
    begin
        #50000;
        failures++;
        complete_run();
    end
endmodule
bind cwd_top cwd_top_sva u_sva (.pclk, .presetn, .array_clear_n, .psel, .penable, .pwrite,
    .paddr, .pslverr, .prog_write, .prog_select_two, .prog_data, .prog_bulk_erase,
    .program_memory_erase, .data_memory_erase, .sleep_mode, .oscillator_select, .watchdog_run,
    .clock_output_drive, .program_protect_on, .data_protect_on, .powerup_timer_on,
    .reset_pin_function, .options_loaded);
